// file: verilog/i2c_sync_pkg.sv
// Constants and types shared by the two-wire bus core and its receive queue
package i2c_sync_pkg;

   // ----------------------------------------------------------------
   // Clock and bus timing
   // ----------------------------------------------------------------
   localparam int MCLK_PERIOD_NS = 8;
   localparam int SCL_LOW_NS     = 5000;
   localparam int SCL_HIGH_NS    = 4000;
   localparam int CNT_W          = 10;
   // Least times round up to whole cycles
   localparam logic [CNT_W-1:0] SCL_LOW_CYC =
      CNT_W'((SCL_LOW_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SCL_HIGH_CYC =
      CNT_W'((SCL_HIGH_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);

   // ----------------------------------------------------------------
   // Byte framing and queue shape
   // ----------------------------------------------------------------
   localparam int             DATA_W       = 8;
   localparam int             ADDR_W       = 7;
   localparam int             RX_DEPTH     = 8;
   localparam logic [3:0]     LAST_DATA    = 4'h7;
   localparam logic [3:0]     ACK_BIT      = 4'h8;
   localparam logic [7:0]     BYTE_RST     = 8'h00;

   // ----------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {stIdle, stStart, stHold, stBit, stStop, stRestart} state_type;
   typedef enum logic [1:0] {phLow, phWait, phHigh} phase_type;

endpackage

// file: verilog/i2c_rx_fifo.sv
// Flip-flop queue with valid and ready on both sides
`timescale 1ns/10ps
module i2c_rx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_b,
   // Filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0]    wrPtr_ff;
   logic [PW-1:0]    rdPtr_ff;
   logic [PW:0]      count_ff;
   logic [PW-1:0]    nxt_wrPtr;
   logic [PW-1:0]    nxt_rdPtr;
   logic [PW:0]      nxt_count;
   logic             push;
   logic             pop;

   assign inReady  = (count_ff != (PW+1)'(DEPTH));
   assign outValid = (count_ff != '0);
   assign outData  = mem_ff[rdPtr_ff];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   always_comb
   begin
      nxt_wrPtr = wrPtr_ff;
      nxt_rdPtr = rdPtr_ff;
      nxt_count = count_ff;
      if (push)
      begin
         nxt_wrPtr = (wrPtr_ff == PW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
      end
      if (pop)
      begin
         nxt_rdPtr = (rdPtr_ff == PW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
      end
      if (push && !pop)
      begin
         nxt_count = count_ff + 1'b1;
      end
      else if (pop && !push)
      begin
         nxt_count = count_ff - 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end
      else
      begin
         wrPtr_ff <= nxt_wrPtr;
         rdPtr_ff <= nxt_rdPtr;
         count_ff <= nxt_count;
      end
   end

   // Storage needs no reset; valid never points at an unwritten word
   always_ff @(posedge mclk)
   begin
      if (push)
      begin
         mem_ff[wrPtr_ff] <= inData;
      end
   end
endmodule

// file: verilog/i2c_sync_core.sv
// Two-wire bus core: clock synchronisation, arbitration and slave handshake
//
// Function
// [RULE_01] Hold clock low until own low count ends
// [RULE_02] Longest low period sets the low phase
// [RULE_03] Wait for line high before counting high
// [RULE_04] First to finish high count pulls low
// [RULE_05] No-ack bit withholds acknowledge on next byte
// [RULE_06] Software clears master select before last read
// [RULE_07] Repeated start then new address, no stop
// [RULE_08] Addressed flag set only after matching address
// [RULE_09] Control register write clears addressed flag
// [RULE_10] Software sets direction from captured read/write
// [RULE_11] Slave stretches clock until data register access; with a full receive queue the access leaves it held
// [RULE_12] Slave transmitter checks ack, dummy read releases
// [RULE_13] Lost master stops data, finishes byte clocks
// [RULE_14] Lost byte ends with flag, master cleared
// [RULE_15] Start on busy bus is refused, master cleared
// [RULE_16] High sent but low seen means lost
// [RULE_17] Falling back to slave sends no stop
// [RULE_18] Lines driven open drain, low or released
`timescale 1ns/10ps
module i2c_sync_core (
   // Clock and reset
   input  wire logic                          mclk,
   input  wire logic                          rst_b,
   // Control bits
   input  wire logic                          masterSelect,
   input  wire logic                          transmitMode,
   input  wire logic                          noAckOnReceive,
   input  wire logic                          repeatStart,
   input  wire logic                          ctrlWrite,
   input  wire logic [i2c_sync_pkg::ADDR_W-1:0] ownAddress,
   input  wire logic                          arbLostClear,
   // Data register access
   input  wire logic [i2c_sync_pkg::DATA_W-1:0] txData,
   input  wire logic                          txWrite,
   input  wire logic                          dataRead,
   // Received bytes
   output logic                               rxValid,
   input  wire logic                          rxReady,
   output logic [i2c_sync_pkg::DATA_W-1:0]    rxData,
   // Status bits
   output logic                               masterActive,
   output logic                               busBusy,
   output logic                               arbitrationLost,
   output logic                               addressedAsSlave,
   output logic                               slaveReadWrite,
   output logic                               receivedAck,
   output logic                               byteDone,
   // Bus pins
   input  wire logic                          sclIn,
   output logic                               sclOut,
   output logic                               sclOe_b,
   input  wire logic                          sdaIn,
   output logic                               sdaOut,
   output logic                               sdaOe_b
);
   import i2c_sync_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic sclMeta_ff;
   logic sclSync_ff;
   logic sclPrev_ff;
   logic sdaMeta_ff;
   logic sdaSync_ff;
   logic sdaPrev_ff;
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         sclMeta_ff <= 1'b1;
         sclSync_ff <= 1'b1;
         sclPrev_ff <= 1'b1;
         sdaMeta_ff <= 1'b1;
         sdaSync_ff <= 1'b1;
         sdaPrev_ff <= 1'b1;
      end
      else
      begin
         sclMeta_ff <= sclIn;
         sclSync_ff <= sclMeta_ff;
         sclPrev_ff <= sclSync_ff;
         sdaMeta_ff <= sdaIn;
         sdaSync_ff <= sdaMeta_ff;
         sdaPrev_ff <= sdaSync_ff;
      end
   end

   assign sclRise   = sclSync_ff && !sclPrev_ff;
   assign sclFall   = !sclSync_ff && sclPrev_ff;
   assign startSeen = sclSync_ff && sclPrev_ff && !sdaSync_ff && sdaPrev_ff;
   assign stopSeen  = sclSync_ff && sclPrev_ff && sdaSync_ff && !sdaPrev_ff;

   // ----------------------------------------------------------------
   // Receive queue
   // ----------------------------------------------------------------
   logic             push;
   logic             fifoReady;
   logic [DATA_W-1:0] shift_ff;

   i2c_rx_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (RX_DEPTH)
   ) u_rx_fifo (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .inValid  (push),
      .inReady  (fifoReady),
      .inData   (shift_ff),
      .outValid (rxValid),
      .outReady (rxReady),
      .outData  (rxData)
   );

   // ----------------------------------------------------------------
   // Transfer engine
   // ----------------------------------------------------------------
   state_type        state_ff,    nxt_state;
   phase_type        phase_ff,    nxt_phase;
   logic [CNT_W-1:0] cnt_ff,      nxt_cnt;
   logic [3:0]       bitCnt_ff,   nxt_bitCnt;
   logic [DATA_W-1:0] nxt_shift;
   logic             isMaster_ff, nxt_isMaster;
   logic             byteTx_ff,   nxt_byteTx;
   logic             isAddr_ff,   nxt_isAddr;
   logic             sclLow_ff,   nxt_sclLow;
   logic             sdaLow_ff,   nxt_sdaLow;
   logic             msBit_ff,    nxt_msBit;
   logic             msPrev_ff;
   logic             busy_ff,     nxt_busy;
   logic             arbLost_ff,  nxt_arbLost;
   logic             addrd_ff,    nxt_addrd;
   logic             srw_ff,      nxt_srw;
   logic             rxAck_ff,    nxt_rxAck;
   logic             done_ff,     nxt_done;
   logic             msRise;
   logic             goByte;
   logic             match;

   assign msRise = masterSelect && !msPrev_ff;
   // A receive byte only starts with a free queue slot, so the push never drops
   assign goByte = (transmitMode ? txWrite : dataRead) && fifoReady;
   assign match  = (shift_ff[7:1] == ownAddress);

   always_comb
   begin
      nxt_state    = state_ff;
      nxt_phase    = phase_ff;
      nxt_cnt      = cnt_ff;
      nxt_bitCnt   = bitCnt_ff;
      nxt_shift    = shift_ff;
      nxt_isMaster = isMaster_ff;
      nxt_byteTx   = byteTx_ff;
      nxt_isAddr   = isAddr_ff;
      nxt_sclLow   = sclLow_ff;
      nxt_sdaLow   = sdaLow_ff;
      nxt_msBit    = msBit_ff;
      nxt_busy     = busy_ff;
      nxt_arbLost  = arbLost_ff;
      nxt_addrd    = addrd_ff;
      nxt_srw      = srw_ff;
      nxt_rxAck    = rxAck_ff;
      nxt_done     = 1'b0;
      push         = 1'b0;

      if (startSeen)
      begin
         nxt_busy = 1'b1;
      end
      else if (stopSeen)
      begin
         nxt_busy = 1'b0;
      end
      if (ctrlWrite)
      begin
         nxt_addrd = 1'b0; // RULE_09
      end
      if (arbLostClear)
      begin
         nxt_arbLost = 1'b0;
      end
      // Refused in any state while someone else holds the bus, held gaps too
      if (msRise && busy_ff && !isMaster_ff)
      begin
         // Bit reads back as zero and the flag marks the refusal
         nxt_msBit   = 1'b0; // RULE_15
         nxt_arbLost = 1'b1; // RULE_15
      end
      if (!masterSelect && !isMaster_ff)
      begin
         nxt_msBit = 1'b0;
      end

      case (state_ff)
         stIdle:
         begin
            nxt_sclLow = 1'b0;
            nxt_sdaLow = 1'b0;
            if (msRise && !busy_ff)
            begin
               nxt_msBit    = 1'b1;
               nxt_isMaster = 1'b1;
               nxt_cnt      = '0;
               nxt_state    = stStart;
            end
         end
         stStart:
         begin
            nxt_sdaLow = 1'b1;
            if (sclSync_ff)
            begin
               nxt_cnt = cnt_ff + 1'b1;
               if (cnt_ff == SCL_HIGH_CYC - 1'b1)
               begin
                  nxt_sclLow = 1'b1;
                  nxt_cnt    = '0;
                  nxt_state  = stHold;
               end
            end
         end
         stHold:
         begin
            nxt_sclLow = 1'b1; // RULE_11
            nxt_phase  = phLow;
            if (isMaster_ff && !masterSelect)
            begin
               nxt_msBit  = 1'b0;
               nxt_sdaLow = 1'b1; // RULE_06
               nxt_cnt    = '0;
               nxt_state  = stStop;
            end
            else if (isMaster_ff && repeatStart)
            begin
               nxt_sdaLow = 1'b0; // RULE_07
               nxt_cnt    = '0;
               nxt_state  = stRestart;
            end
            else if (goByte)
            begin
               nxt_byteTx = transmitMode;
               nxt_bitCnt = '0;
               nxt_cnt    = '0;
               nxt_sclLow = isMaster_ff;
               if (txWrite)
               begin
                  nxt_shift = txData;
               end
               nxt_sdaLow = transmitMode && !txData[7];
               nxt_state  = stBit;
            end
         end
         stBit:
         begin
            if (isMaster_ff)
            begin
               case (phase_ff)
                  phLow:
                  begin
                     nxt_sclLow = 1'b1; // RULE_01
                     nxt_cnt    = cnt_ff + 1'b1;
                     if (cnt_ff == SCL_LOW_CYC - 1'b1)
                     begin
                        nxt_sclLow = 1'b0;
                        nxt_cnt    = '0;
                        nxt_phase  = phWait;
                     end
                  end
                  phWait:
                  begin
                     // Another device may still be counting its low period
                     if (sclSync_ff)
                     begin
                        nxt_cnt   = '0;
                        nxt_phase = phHigh; // RULE_03
                     end
                  end
                  phHigh:
                  begin
                     nxt_cnt = cnt_ff + 1'b1;
                     if (!sclSync_ff)
                     begin
                        nxt_sclLow = 1'b1; // RULE_02
                        nxt_cnt    = '0;
                        nxt_phase  = phLow;
                     end
                     else if (cnt_ff == SCL_HIGH_CYC - 1'b1)
                     begin
                        nxt_sclLow = 1'b1; // RULE_04
                        nxt_cnt    = '0;
                        nxt_phase  = phLow;
                     end
                  end
                  default:
                  begin
                     nxt_phase = phLow;
                  end
               endcase
            end
            else
            begin
               nxt_sclLow = 1'b0;
               // The start's own clock fall carries no bit
               if (sclFall)
               begin
                  nxt_phase = phLow;
               end
            end
            if (sclRise)
            begin
               if (bitCnt_ff == ACK_BIT)
               begin
                  if (byteTx_ff)
                  begin
                     nxt_rxAck = sdaSync_ff; // RULE_12
                  end
               end
               else
               begin
                  nxt_shift = {shift_ff[6:0], sdaSync_ff};
                  if (isMaster_ff && byteTx_ff && !sdaLow_ff && !sdaSync_ff)
                  begin
                     nxt_arbLost = 1'b1; // RULE_16
                     nxt_msBit   = 1'b0; // RULE_13
                     nxt_byteTx  = 1'b0; // RULE_13
                  end
               end
            end
            if (sclFall && (isMaster_ff || phase_ff != phWait))
            begin
               nxt_bitCnt = bitCnt_ff + 1'b1;
               if (bitCnt_ff < LAST_DATA)
               begin
                  nxt_sdaLow = byteTx_ff && !shift_ff[7];
               end
               else if (bitCnt_ff == LAST_DATA)
               begin
                  if (byteTx_ff)
                  begin
                     nxt_sdaLow = 1'b0;
                  end
                  else if (isAddr_ff)
                  begin
                     nxt_sdaLow = match;
                  end
                  else
                  begin
                     nxt_sdaLow = !noAckOnReceive; // RULE_05
                  end
               end
               else
               begin
                  nxt_done   = 1'b1; // RULE_14
                  nxt_sdaLow = 1'b0;
                  nxt_isAddr = 1'b0;
                  nxt_addrd  = 1'b0; // RULE_08
                  push       = !byteTx_ff && !isAddr_ff;
                  nxt_state  = stHold;
                  if (isAddr_ff)
                  begin
                     nxt_addrd = match; // RULE_08
                     nxt_srw   = shift_ff[0];
                     nxt_state = match ? stHold : stIdle;
                  end
                  else if (isMaster_ff && !msBit_ff)
                  begin
                     // Drop to listening without touching the data line
                     nxt_isMaster = 1'b0; // RULE_17
                     nxt_sclLow   = 1'b0;
                     nxt_state    = stIdle;
                  end
               end
            end
         end
         stStop, stRestart:
         begin
            case (phase_ff)
               phLow:
               begin
                  nxt_cnt = cnt_ff + 1'b1;
                  if (cnt_ff == SCL_LOW_CYC - 1'b1)
                  begin
                     nxt_sclLow = 1'b0;
                     nxt_cnt    = '0;
                     nxt_phase  = phWait;
                  end
               end
               phWait:
               begin
                  if (sclSync_ff)
                  begin
                     nxt_cnt   = '0;
                     nxt_phase = phHigh;
                  end
               end
               default:
               begin
                  nxt_cnt = cnt_ff + 1'b1;
                  if (cnt_ff == SCL_HIGH_CYC - 1'b1)
                  begin
                     nxt_cnt   = '0;
                     nxt_phase = phLow;
                     if (state_ff == stStop)
                     begin
                        nxt_sdaLow   = 1'b0;
                        nxt_isMaster = 1'b0;
                        nxt_state    = stIdle;
                     end
                     else
                     begin
                        nxt_sdaLow = 1'b1; // RULE_07
                        nxt_state  = stStart;
                     end
                  end
               end
            endcase
         end
         default:
         begin
            nxt_state = stIdle;
         end
      endcase

      // A start or stop made by someone else resets the listening slave
      if (!isMaster_ff && (startSeen || stopSeen) && state_ff != stIdle || 
          !isMaster_ff && startSeen)
      begin
         nxt_sclLow = 1'b0;
         nxt_sdaLow = 1'b0;
         nxt_state  = stopSeen ? stIdle : stBit;
         nxt_bitCnt = '0;
         nxt_byteTx = 1'b0;
         nxt_isAddr = startSeen;
         nxt_phase  = startSeen ? phWait : phLow;
      end
      if (state_ff == stIdle && msRise && !busy_ff)
      begin
         nxt_state = stStart;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         state_ff    <= stIdle;
         phase_ff    <= phLow;
         cnt_ff      <= '0;
         bitCnt_ff   <= '0;
         shift_ff    <= BYTE_RST;
         isMaster_ff <= 1'b0;
         byteTx_ff   <= 1'b0;
         isAddr_ff   <= 1'b0;
         sclLow_ff   <= 1'b0;
         sdaLow_ff   <= 1'b0;
         msBit_ff    <= 1'b0;
         msPrev_ff   <= 1'b0;
         busy_ff     <= 1'b0;
         arbLost_ff  <= 1'b0;
         addrd_ff    <= 1'b0;
         srw_ff      <= 1'b0;
         rxAck_ff    <= 1'b0;
         done_ff     <= 1'b0;
      end
      else
      begin
         state_ff    <= nxt_state;
         phase_ff    <= nxt_phase;
         cnt_ff      <= nxt_cnt;
         bitCnt_ff   <= nxt_bitCnt;
         shift_ff    <= nxt_shift;
         isMaster_ff <= nxt_isMaster;
         byteTx_ff   <= nxt_byteTx;
         isAddr_ff   <= nxt_isAddr;
         sclLow_ff   <= nxt_sclLow;
         sdaLow_ff   <= nxt_sdaLow;
         msBit_ff    <= nxt_msBit;
         msPrev_ff   <= masterSelect;
         busy_ff     <= nxt_busy;
         arbLost_ff  <= nxt_arbLost;
         addrd_ff    <= nxt_addrd;
         srw_ff      <= nxt_srw;
         rxAck_ff    <= nxt_rxAck;
         done_ff     <= nxt_done;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Only ever pull low; the high level comes from the pull-up
   assign sclOut           = 1'b0; // RULE_18
   assign sdaOut           = 1'b0; // RULE_18
   assign sclOe_b          = !sclLow_ff; // RULE_18
   assign sdaOe_b          = !sdaLow_ff; // RULE_18
   assign masterActive     = msBit_ff;
   assign busBusy          = busy_ff;
   assign arbitrationLost  = arbLost_ff;
   assign addressedAsSlave = addrd_ff;
   assign slaveReadWrite   = srw_ff;
   assign receivedAck      = rxAck_ff;
   assign byteDone         = done_ff;
endmodule

// file: tb/i2c_sync_checker.sv
// Concurrent checks on the two-wire core ports
`timescale 1ns/10ps
module i2c_sync_checker (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Control strobes
   input wire logic masterSelect,
   input wire logic ctrlWrite,
   input wire logic dataRead,
   input wire logic arbLostClear,
   // Status and pins
   input wire logic masterActive,
   input wire logic busBusy,
   input wire logic arbitrationLost,
   input wire logic addressedAsSlave,
   input wire logic byteDone,
   input wire logic sclOut,
   input wire logic sdaOut,
   input wire logic sclOe_b
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ----
   // Properties
   // ----
   out_tied_a: assert property (!sclOut && !sdaOut)
      else $error("pin output not low");
   idle_release_a: assert property (!busBusy && !masterActive |-> sclOe_b)
      else $error("clock pulled while idle");
   stretch_hold_a: assert property (addressedAsSlave && !sclOe_b && !dataRead |=> !sclOe_b)
      else $error("clock released early");
   addr_mark_a: assert property ($rose(addressedAsSlave) |-> ##[0:2] (busBusy && !sclOe_b))
      else $error("addressed flag outside gap");
   addr_clear_a: assert property (ctrlWrite && addressedAsSlave && !byteDone |=> !addressedAsSlave)
      else $error("addressed flag kept");
   done_pulse_a: assert property (byteDone |=> !byteDone)
      else $error("byte end too long");
   lost_sticky_a: assert property (arbitrationLost && !arbLostClear |=> arbitrationLost)
      else $error("lost flag dropped");
   refuse_flag_a: assert property ($rose(masterSelect) && busBusy |-> ##[1:3] arbitrationLost)
      else $error("busy start not flagged");
   refuse_master_a: assert property ($rose(masterSelect) && busBusy |-> !masterActive [*4])
      else $error("busy start went master");
   cover property (byteDone && addressedAsSlave);
   cover property ($rose(arbitrationLost));
   cover property ($fell(busBusy));
endmodule
bind i2c_sync_core i2c_sync_checker chk_u (.mclk, .rst_b, .masterSelect, .ctrlWrite,
   .dataRead, .arbLostClear, .masterActive, .busBusy, .arbitrationLost,
   .addressedAsSlave, .byteDone, .sclOut, .sdaOut, .sclOe_b);

// file: tb/i2c_bus_partner.sv
// Behavioural far-side bus master
`timescale 1ns/10ps
module i2c_bus_partner (
   // Clock
   input wire logic mclk,
   // Wired lines, release is high
   input wire logic sclLine,
   input wire logic sdaLine,
   output logic     sclRel,
   output logic     sdaRel
);
   // ----
   // Bus conditions
   // ----
   initial
   begin
      sclRel = 1'b1;
      sdaRel = 1'b1;
   end
   // Half of an 80 ns link clock
   task automatic half();
      repeat (5) @(posedge mclk);
      #1;
   endtask
   task automatic start();
      sdaRel = 1'b0;
      half();
      sclRel = 1'b0;
      half();
   endtask
   // Waiting on the line lets a slave stretch as long as it likes
   task automatic bitOut(input logic b, output logic s);
      sdaRel = b;
      half();
      sclRel = 1'b1;
      wait (sclLine);
      half();
      s = sdaLine;
      sclRel = 1'b0;
   endtask
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bitOut(d[i], s);
      bitOut(1'b1, ack);
   endtask
   task automatic stop();
      sdaRel = 1'b0;
      half();
      sclRel = 1'b1;
      wait (sclLine);
      half();
      sdaRel = 1'b1;
      half();
   endtask
endmodule

// file: tb/i2c_sync_arbitration_slave_test.sv
// Self-checking bench for the core in slave receive
`timescale 1ns/10ps
module i2c_sync_arbitration_slave_test;
   import i2c_sync_pkg::*;
   logic        mclk, rst_b, masterSelect, noAckOnReceive, ctrlWrite, arbLostClear;
   logic        dataRead, rxReady, rxValid, masterActive, busBusy, arbitrationLost;
   logic        addressedAsSlave, slaveReadWrite, receivedAck, byteDone, ack;
   logic        sclOut, sclOe_b, sdaOut, sdaOe_b, sclRel, sdaRel;
   logic [6:0]  own;
   logic [7:0]  rxData;
   logic [31:0] rng;
   wire         sclL = sclOe_b & sclRel;
   wire         sdaL = sdaOe_b & sdaRel;
   int          bad_count, compares;
   int          q[$];
   i2c_sync_core dut_u (.mclk, .rst_b, .masterSelect, .transmitMode(1'b0),
      .noAckOnReceive, .repeatStart(1'b0), .ctrlWrite, .ownAddress(own), .arbLostClear,
      .txData(8'h00), .txWrite(1'b0), .dataRead, .rxValid, .rxReady, .rxData,
      .masterActive, .busBusy, .arbitrationLost, .addressedAsSlave, .slaveReadWrite,
      .receivedAck, .byteDone, .sclIn(sclL), .sclOut, .sclOe_b, .sdaIn(sdaL), .sdaOut,
      .sdaOe_b);
   i2c_bus_partner p_u (.mclk, .sclLine(sclL), .sdaLine(sdaL), .sclRel, .sdaRel);
   // ----
   // Helpers
   // ----
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   task automatic check(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1)
      begin
         bad_count++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic pulseRead();
      dataRead = 1'b1;
      tick(1);
      dataRead = 1'b0;
      tick(4);
   endtask
   task automatic waitDone();
      int n;
      n = 0;
      while (byteDone !== 1'b1 && n < 100)
      begin
         tick(1);
         n++;
      end
      check(n < 100, "no byte end");
      tick(1);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Over twenty times the expected run
   initial
   begin
      tick(30000);
      bad_count++;
      results();
   end
   initial
   begin
      rng = 32'h0000004A;
      {rst_b, masterSelect, noAckOnReceive, ctrlWrite, arbLostClear, dataRead, rxReady} = '0;
      own = 7'(rnd());
      tick(3);
      rst_b = 1'b1;
      tick(3);
      check(sclOe_b & sdaOe_b & !busBusy & !arbitrationLost & !rxValid & !receivedAck,
         "reset state");
      p_u.start();
      p_u.sendByte({~own, 1'b0}, ack);
      check({ack, addressedAsSlave} === 2'b10, "foreign address");
      p_u.stop();
      p_u.start();
      p_u.sendByte({own, 1'b0}, ack);
      waitDone();
      check({ack, addressedAsSlave, slaveReadWrite} === 3'b010, "own address");
      tick(20);
      check({sclOe_b, sclL} === 2'b00, "clock held");
      masterSelect = 1'b1;
      tick(4);
      check({arbitrationLost, masterActive} === 2'b10, "start refused");
      {masterSelect, arbLostClear, ctrlWrite} = 3'b011;
      tick(1);
      {arbLostClear, ctrlWrite} = 2'b00;
      tick(1);
      check({arbitrationLost, addressedAsSlave} === 2'b00, "flags cleared");
      // Eight bytes fill the queue while nobody drains it
      for (int i = 0; i < 8; i++)
      begin
         q.push_back(int'(rnd() & 32'h000000FF));
         noAckOnReceive = (i == 7);
         pulseRead();
         check(sclOe_b === 1'b1, "clock released");
         p_u.sendByte(8'(q[i]), ack);
         waitDone();
         check({ack, addressedAsSlave} === {noAckOnReceive, 1'b0}, "data byte");
      end
      pulseRead();
      check(sclOe_b === 1'b0, "full queue holds clock");
      rxReady = 1'b1;
      while (q.size() > 0)
      begin
         check({rxValid, rxData} === {1'b1, 8'(q.pop_front())}, "received data");
         tick(1);
      end
      rxReady = 1'b0;
      pulseRead();
      check({rxValid, sclOe_b} === 2'b01, "queue drained");
      p_u.stop();
      results();
   end
endmodule
